// *** inc/dec_defines.vh ***
/*
 * constants of the debug event flags, sequencer status and comparator A block:
 * register indexes, field positions, state codes and bus answers.
 * assumes it is included by bare name into the design file.
 */
`ifndef DEC_DEFINES_VH
`define DEC_DEFINES_VH

// register indexes; byte address is four times the index
`define DEC_IDX_EVENT_FLAGS 10'h10A
`define DEC_IDX_SEQ_STATUS 10'h10B
`define DEC_IDX_CTL 10'h110
`define DEC_IDX_ADDR_HI 10'h115
`define DEC_IDX_ADDR_MID 10'h116
`define DEC_IDX_ADDR_LO 10'h117
`define DEC_IDX_DATA0 10'h118
`define DEC_IDX_DATA1 10'h119
`define DEC_IDX_DATA2 10'h11A
`define DEC_IDX_DATA3 10'h11B

// event flag field positions
`define DEC_EF_FORCED_BREAKPOINT_REQUEST 6
`define DEC_EF_EXT 4
`define DEC_EF_ME_HI 3
`define DEC_EF_ME_LO 0

// comparator control field positions
`define DEC_CTL_NDB 6
`define DEC_CTL_PC_COMPARE_SELECT 5
`define DEC_CTL_RW 3
`define DEC_CTL_RWE 2
`define DEC_CTL_EN 0
`define DEC_CTL_MASK 8'h6D

// sequencer status codes
`define DEC_SS_DISARMED 3'h0
`define DEC_SS_FIRST 3'h1
`define DEC_SS_SECOND 3'h2
`define DEC_SS_THIRD 3'h3
`define DEC_SS_FINAL 3'h4

// reset values and bus answers
`define DEC_RST_BYTE 8'h00
`define DEC_RST_WORD 32'h00000000
`define DEC_RESP_OKAY 2'h0
`define DEC_RESP_SLVERR 2'h2

`endif

// *** hdl/dec_core.v ***
/*
 * event flags, sequencer status field and comparator channel A of an on-chip
 * debug unit, with an axi4-lite register slave.
 * assumes the arm level, sequencer steps and session end come from the rest
 * of the debug unit, all inputs are synchronous to aclk.
 */
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "dec_defines.vh"

module dec_core (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire arm,
	input wire forced_trigger_event,
	input wire external_event,
	input wire [3:1] other_channel_match,
	input wire seq_step,
	input wire [2:0] seq_next_state,
	input wire session_end_internal,
	input wire [31:0] data_mask,
	input wire cpu_data_valid,
	input wire [23:0] cpu_data_addr,
	input wire [31:0] cpu_data,
	input wire cpu_read,
	input wire cpu_pc_valid,
	input wire [23:0] cpu_pc,
	output reg comp_a_match
);

	reg arm_q;
	reg [3:0] channel_match_flags;
	reg external_event_flag;
	reg forced_trigger_flag;
	reg [2:0] sequencer_status_field;
	reg [7:0] comparator_a_control;
	reg [23:0] address_compare_value;
	reg [31:0] data_compare_value;

	reg aw_got;
	reg [9:0] aw_idx;
	reg w_got;
	reg [7:0] w_byte;
	reg w_lane0;

	wire arming;
	wire [3:0] match_events;
	wire [31:0] data_diff;
	wire data_differs;
	wire data_ok;
	wire dir_ok;
	wire next_hit;
	wire do_write;
	wire [9:0] ar_idx;

	assign arming = arm & ~arm_q;

	// ---------------- comparator A ----------------
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_data_bit
			// a bit only counts where its mask bit is set
			assign data_diff[gi] = data_mask[gi] & (cpu_data[gi] ^ data_compare_value[gi]);
		end
	endgenerate

	assign data_differs = |data_diff;
	assign data_ok = comparator_a_control[`DEC_CTL_NDB] ? data_differs : ~data_differs;
	assign dir_ok = ~comparator_a_control[`DEC_CTL_RWE] |
		(comparator_a_control[`DEC_CTL_RW] == cpu_read);

	// pc compare ignores data and direction, as instruction fetches carry neither
	assign next_hit = comparator_a_control[`DEC_CTL_EN] &
		(comparator_a_control[`DEC_CTL_PC_COMPARE_SELECT] ?
		(cpu_pc_valid & (cpu_pc == address_compare_value)) :
		(cpu_data_valid & (cpu_data_addr == address_compare_value) & data_ok & dir_ok));

	assign match_events = {other_channel_match, next_hit};

	always @(posedge aclk) begin
		if (!aresetn) begin
			comp_a_match <= 1'b0;
		end else begin
			comp_a_match <= next_hit;
		end
	end

	// ---------------- event flags and sequencer status ----------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			arm_q <= 1'b0;
			channel_match_flags <= 4'h0;
			external_event_flag <= 1'b0;
			forced_trigger_flag <= 1'b0;
			sequencer_status_field <= `DEC_SS_DISARMED;
		end else begin
			arm_q <= arm;
			if (arming) begin
				// clear on arming, but an event in the same cycle still sets
				channel_match_flags <= match_events;
				external_event_flag <= external_event;
				forced_trigger_flag <= forced_trigger_event;
			end else if (arm) begin
				channel_match_flags <= channel_match_flags | match_events;
				external_event_flag <= external_event_flag | external_event;
				forced_trigger_flag <= forced_trigger_flag | forced_trigger_event;
			end
			if (session_end_internal) begin
				sequencer_status_field <= `DEC_SS_DISARMED;
			end else if (arming) begin
				sequencer_status_field <= `DEC_SS_FIRST;
			end else if (arm && seq_step && seq_next_state <= `DEC_SS_FINAL) begin
				// reserved codes never reach the field
				sequencer_status_field <= seq_next_state;
			end
			// disarm by software falls through and keeps the last state
		end
	end

	// ---------------- axi4-lite write ----------------
	assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
	assign s_axi_wready = ~w_got & ~s_axi_bvalid;
	assign do_write = aw_got & w_got & ~s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			aw_idx <= 10'h000;
			w_got <= 1'b0;
			w_byte <= `DEC_RST_BYTE;
			w_lane0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DEC_RESP_OKAY;
			comparator_a_control <= `DEC_RST_BYTE;
			address_compare_value <= 24'h000000;
			data_compare_value <= `DEC_RST_WORD;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_idx <= s_axi_awaddr[11:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (do_write) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `DEC_RESP_OKAY;
				// armed writes are dropped silently so a live session stays consistent
				case (aw_idx)
				`DEC_IDX_EVENT_FLAGS, `DEC_IDX_SEQ_STATUS: begin
					// read-only, write ignored
				end
				`DEC_IDX_CTL: begin
					if (!arm && w_lane0) begin
						comparator_a_control <= w_byte & `DEC_CTL_MASK;
					end
				end
				`DEC_IDX_ADDR_HI: begin
					if (!arm && w_lane0) begin
						address_compare_value[23:16] <= w_byte;
					end
				end
				`DEC_IDX_ADDR_MID: begin
					if (!arm && w_lane0) begin
						address_compare_value[15:8] <= w_byte;
					end
				end
				`DEC_IDX_ADDR_LO: begin
					if (!arm && w_lane0) begin
						address_compare_value[7:0] <= w_byte;
					end
				end
				`DEC_IDX_DATA0: begin
					if (!arm && w_lane0) begin
						data_compare_value[31:24] <= w_byte;
					end
				end
				`DEC_IDX_DATA1: begin
					if (!arm && w_lane0) begin
						data_compare_value[23:16] <= w_byte;
					end
				end
				`DEC_IDX_DATA2: begin
					if (!arm && w_lane0) begin
						data_compare_value[15:8] <= w_byte;
					end
				end
				`DEC_IDX_DATA3: begin
					if (!arm && w_lane0) begin
						data_compare_value[7:0] <= w_byte;
					end
				end
				default: begin
					s_axi_bresp <= `DEC_RESP_SLVERR;
				end
				endcase
			end
		end
	end

	// ---------------- axi4-lite read ----------------
	assign s_axi_arready = ~s_axi_rvalid;
	assign ar_idx = s_axi_araddr[11:2];

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `DEC_RST_WORD;
			s_axi_rresp <= `DEC_RESP_OKAY;
		end else begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `DEC_RESP_OKAY;
				s_axi_rdata <= `DEC_RST_WORD;
				case (ar_idx)
				`DEC_IDX_EVENT_FLAGS: begin
					s_axi_rdata[`DEC_EF_FORCED_BREAKPOINT_REQUEST] <= forced_trigger_flag;
					s_axi_rdata[`DEC_EF_EXT] <= external_event_flag;
					s_axi_rdata[`DEC_EF_ME_HI:`DEC_EF_ME_LO] <= channel_match_flags;
				end
				`DEC_IDX_SEQ_STATUS: begin
					s_axi_rdata[2:0] <= sequencer_status_field;
				end
				`DEC_IDX_CTL: begin
					s_axi_rdata[7:0] <= comparator_a_control;
				end
				`DEC_IDX_ADDR_HI: begin
					s_axi_rdata[7:0] <= address_compare_value[23:16];
				end
				`DEC_IDX_ADDR_MID: begin
					s_axi_rdata[7:0] <= address_compare_value[15:8];
				end
				`DEC_IDX_ADDR_LO: begin
					s_axi_rdata[7:0] <= address_compare_value[7:0];
				end
				`DEC_IDX_DATA0: begin
					s_axi_rdata[7:0] <= data_compare_value[31:24];
				end
				`DEC_IDX_DATA1: begin
					s_axi_rdata[7:0] <= data_compare_value[23:16];
				end
				`DEC_IDX_DATA2: begin
					s_axi_rdata[7:0] <= data_compare_value[15:8];
				end
				`DEC_IDX_DATA3: begin
					s_axi_rdata[7:0] <= data_compare_value[7:0];
				end
				default: begin
					s_axi_rresp <= `DEC_RESP_SLVERR;
				end
				endcase
			end
		end
	end

endmodule // dec_core

// *** verif/dec_core_assertions.sv ***
/* port checker of dec_core
   assumes one clock and the synchronous low reset */
`timescale 1ns/10ps
module dec_core_assertions (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire cpu_data_valid,
	input wire cpu_pc_valid,
	input wire comp_a_match
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire ar = s_axi_arvalid & s_axi_arready;
	wire [9:0] ri = s_axi_araddr[11:2];
	// one write at a time, so a taken response cannot be followed at once
	a_b_clear: assert property (s_axi_bvalid & s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid not cleared");
	a_ar_answer: assert property (ar |=> s_axi_rvalid) else $error("no read answer");
	a_w_answer: assert property (s_axi_awvalid & s_axi_awready & s_axi_wvalid
		& s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
	a_match_cause: assert property (!cpu_data_valid & !cpu_pc_valid |=> !comp_a_match)
		else $error("match without access");
	a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_flag_layout: assert property (ar & ri == 10'h10A |=> (s_axi_rdata & 32'hA0) == 0)
		else $error("flag spare bits set");
	a_status_code: assert property (ar & ri == 10'h10B |=> s_axi_rdata <= 32'h4)
		else $error("reserved status code");
	a_ctl_layout: assert property (ar & ri == 10'h110 |=> (s_axi_rdata & 32'h92) == 0)
		else $error("control spare bits set");
	a_unmapped: assert property (ar & ri < 10'h10A |=> s_axi_rresp == 2'h2)
		else $error("unmapped read not refused");
	cover property (comp_a_match);
	cover property (ar & ri == 10'h10B);
	cover property (s_axi_bvalid & s_axi_bready);
endmodule // dec_core_assertions

bind dec_core dec_core_assertions i_chk (.*);

// *** verif/dec_cpu_model.sv ***
/* cpu core bus model: one data access or pc fetch per call
   assumes the bench calls acc right after a clock edge */
`timescale 1ns/10ps
module dec_cpu_model (
	input wire aclk,
	output logic cpu_data_valid,
	output logic [23:0] cpu_data_addr,
	output logic [31:0] cpu_data,
	output logic cpu_read,
	output logic cpu_pc_valid,
	output logic [23:0] cpu_pc
);
	initial begin
		{cpu_data_valid, cpu_data_addr, cpu_data, cpu_read, cpu_pc_valid, cpu_pc} = '0;
	end
	task acc(input logic p, input logic [23:0] a, input logic [31:0] d, input logic r);
		@(posedge aclk);
		{cpu_data_valid, cpu_pc_valid} <= {!p, p};
		{cpu_data_addr, cpu_pc, cpu_data, cpu_read} <= {a, a, d, r};
		@(posedge aclk);
		{cpu_data_valid, cpu_pc_valid} <= 2'h0;
		// idle lines turn over so stale values cannot fake a match
		{cpu_data_addr, cpu_pc, cpu_data, cpu_read} <= ~{a, a, d, r};
	endtask
endmodule // dec_cpu_model

// *** verif/tb_dec_core.sv ***
/* bench of dec_core with the cpu bus model
   assumes the checker binds itself to dec_core */
`timescale 1ns/10ps
module tb_dec_core;
	localparam logic [23:0] AV = 24'h123456;
	localparam logic [31:0] DV = 32'hA5B6C7D8;
	localparam logic [1:0] OK = 2'h0;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, arm = 0, forced_trigger_event = 0;
	logic external_event = 0, seq_step = 0, session_end_internal = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0, other_channel_match = 0;
	logic [2:0] seq_next_state = 3'h3;
	logic [31:0] s_axi_wdata = 0, data_mask = 32'hFFFFFFFF;
	logic [3:0] s_axi_wstrb = 4'h1;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata, cpu_data;
	wire [23:0] cpu_data_addr, cpu_pc;
	wire cpu_data_valid, cpu_read, cpu_pc_valid, comp_a_match;
	int num_errors = 0, cmp_count = 0;
	dec_core i_dut (.*);
	dec_cpu_model i_cpu (.*);
	always #5 aclk = ~aclk;
	task chk(input logic [33:0] g, input logic [33:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] e);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {i, 2'h0, 24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk({32'h0, s_axi_bresp}, {32'h0, e});
	endtask
	task rd(input logic [9:0] i, input logic [7:0] x, input logic [1:0] e);
		@(posedge aclk);
		s_axi_araddr <= {i, 2'h0};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		chk({s_axi_rresp, e == OK ? s_axi_rdata : 32'h0}, {e, 24'h0, x});
	endtask
	task cm(input logic [7:0] c, input logic p, input logic [23:0] a, input logic [31:0] d,
		input logic r, input logic e);
		wr(10'h110, c, OK);
		i_cpu.acc(p, a, d, r);
		#1;
		chk({33'h0, comp_a_match}, {33'h0, e});
	endtask
	// one cycle of events, then all pulses drop; arm keeps its level
	task drive(input logic a, t, x, input logic [2:0] o, input logic s, q);
		@(posedge aclk);
		{arm, forced_trigger_event, external_event, other_channel_match} <= {a, t, x, o};
		{seq_step, session_end_internal} <= {s, q};
		@(posedge aclk);
		{forced_trigger_event, external_event, other_channel_match} <= 5'h0;
		{seq_step, session_end_internal} <= 2'h0;
	endtask
	task t_regs;
		rd(10'h10B, 8'h00, OK);
		wr(10'h10A, 8'hFF, OK);
		wr(10'h10B, 8'h07, OK);
		rd(10'h10A, 8'h00, OK);
		rd(10'h10B, 8'h00, OK);
		wr(10'h110, 8'hFF, OK);
		rd(10'h110, 8'h6D, OK);
		wr(10'h100, 8'hFF, 2'h2);
		rd(10'h100, 8'h00, 2'h2);
	endtask
	task t_match;
		for (int k = 0; k < 3; k++) wr(10'h115 + k, 8'h12 + 8'h22 * k, OK);
		for (int k = 0; k < 4; k++) begin
			wr(10'h118 + k, 8'hA5 + 8'h11 * k, OK);
			rd(10'h118 + k, 8'hA5 + 8'h11 * k, OK);
		end
		cm(8'h01, 0, AV, DV, 1, 1);
		cm(8'h01, 0, AV + 1, DV, 1, 0);
		cm(8'h01, 0, AV ^ 24'h800000, DV, 1, 0);
		cm(8'h01, 0, AV, DV + 1, 1, 0);
		@(posedge aclk);
		data_mask <= 32'hFFFFFFFE;
		cm(8'h01, 0, AV, DV + 1, 1, 1);
		@(posedge aclk);
		data_mask <= 32'hFFFFFFFF;
		cm(8'h41, 0, AV, DV + 1, 1, 1);
		cm(8'h41, 0, AV, DV, 1, 0);
		cm(8'h0D, 0, AV, DV, 0, 0);
		cm(8'h0D, 0, AV, DV, 1, 1);
		cm(8'h05, 0, AV, DV, 0, 1);
		cm(8'h00, 0, AV, DV, 1, 0);
		cm(8'h21, 1, AV, DV, 0, 1);
		cm(8'h21, 0, AV, DV, 1, 0);
		cm(8'h6D, 1, AV, 32'h0, 1, 1);
	endtask
	task t_arm;
		wr(10'h110, 8'h01, OK);
		drive(0, 1, 1, 3'h7, 1, 0);
		rd(10'h10A, 8'h00, OK);
		drive(1, 1, 0, 3'h0, 0, 0);
		rd(10'h10A, 8'h40, OK);
		rd(10'h10B, 8'h01, OK);
		drive(1, 0, 1, 3'h5, 1, 0);
		cm(8'h00, 0, AV, DV, 1, 1);
		rd(10'h10A, 8'h5B, OK);
		rd(10'h10B, 8'h03, OK);
		// a reserved code offered by the sequencer must not reach the field
		@(posedge aclk);
		seq_next_state <= 3'h6;
		drive(1, 0, 0, 3'h0, 1, 0);
		rd(10'h10B, 8'h03, OK);
		@(posedge aclk);
		seq_next_state <= 3'h3;
		drive(0, 0, 0, 3'h0, 1, 0);
		rd(10'h10B, 8'h03, OK);
		rd(10'h10A, 8'h5B, OK);
		drive(1, 0, 0, 3'h0, 0, 0);
		rd(10'h10A, 8'h00, OK);
		drive(1, 0, 0, 3'h0, 0, 1);
		rd(10'h10B, 8'h00, OK);
		drive(0, 0, 0, 3'h0, 0, 0);
	endtask
	task wrap_up;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		t_regs;
		t_match;
		t_arm;
		wrap_up;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		wrap_up;
	end
endmodule // tb_dec_core
